// ---- hdl/ubs_defines.svh ----
/*
  Register offsets, field positions, reset values and frame constants
  of the serial channel. Assumes it is included by bare name by the
  design, checker and bench modules; definitions only.
*/
`ifndef UBS_DEFINES_SVH
`define UBS_DEFINES_SVH

// ****************************************************************
// register byte offsets (haddr[7:0])
// ****************************************************************
`define UBS_OFS_MODE        8'h00
`define UBS_OFS_CTRL1       8'h04
`define UBS_OFS_RXBUF       8'h08
`define UBS_OFS_TXBUF       8'h0c
`define UBS_OFS_BAUD        8'h10

// ****************************************************************
// mode register fields
// ****************************************************************
`define UBS_MODE_SMD_LO     0
`define UBS_MODE_SMD_HI     2
`define UBS_MODE_STOP2      4
`define UBS_MODE_PAR_EVEN   5
`define UBS_MODE_PAR_EN     6
`define UBS_SMD_UART8       3'h5

// ****************************************************************
// channel_control_one fields
// ****************************************************************
`define UBS_C1_TX_EN        0
`define UBS_C1_TX_EMPTY     1
`define UBS_C1_RE           2
`define UBS_C1_RX_DONE      3

// ****************************************************************
// receive_buffer fields
// ****************************************************************
`define UBS_RB_OVERRUN      12
`define UBS_RB_FRAMING      13
`define UBS_RB_PARITY       14
`define UBS_RB_SUM          15

// ****************************************************************
// reset values and frame timing
// ****************************************************************
`define UBS_RST_SMD         3'h0
`define UBS_RST_BAUD        8'h00
`define UBS_OVERSAMPLE_MAX  4'hf
`define UBS_MID_SAMPLE      4'h7
`define UBS_TX_BITS_BASE    4'h9
`define UBS_RX_BITS_BASE    4'ha

`endif

// ---- hdl/ubs_pkg.sv ----
/*
  Types of the serial channel: one-hot state codes and the packed
  state records of the channel and of its baud generator. Assumes
  the defines header sits beside it.
*/
package ubs_pkg;

  typedef enum logic [1:0]
  {
    UBS_TX_IDLE = 2'b01,
    UBS_TX_RUN  = 2'b10
  } ubs_tx_state_t;

  typedef enum logic [1:0]
  {
    UBS_RX_IDLE = 2'b01,
    UBS_RX_RUN  = 2'b10
  } ubs_rx_state_t;

  typedef struct packed
  {
    logic [7:0] cnt;
    logic       tick;
  } ubs_baud_st_t;

  typedef struct packed
  {
    logic [2:0]    smd;
    logic          stop2;
    logic          par_even;
    logic          par_en;
    logic          tx_en;
    logic          re;
    logic [7:0]    baud;
    logic          pend_wr;
    logic          pend_rd;
    logic [7:0]    addr;
    logic          hready;
    logic          hresp;
    logic [31:0]   hrdata;
    ubs_tx_state_t tx_state;
    logic [7:0]    tx_buf;
    logic          tx_full;
    logic [10:0]   tx_shift;
    logic [3:0]    tx_left;
    logic [3:0]    tx_sub;
    logic          txd;
    logic          rx_sync1;
    logic          rx_sync2;
    ubs_rx_state_t rx_state;
    logic [3:0]    rx_sub;
    logic [3:0]    rx_left;
    logic [9:0]    rx_shift;
    logic [7:0]    rb_data;
    logic          rx_done;
    logic          overrun;
    logic          framing;
    logic          par_err;
  } ubs_st_t;

endpackage

// ---- hdl/ubs_baud_gen.sv ----
/*
  Baud generator: divides hclk by the programmed value plus one and
  gives a one-cycle enable at sixteen times the bit rate. Assumes the
  divider value is stable or that a change may take one period.
*/
`timescale 1ns/100ps
`include "ubs_defines.svh"

module ubs_baud_gen
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic [7:0] divider,
  output logic            tick16
);
  import ubs_pkg::*;

  ubs_baud_st_t st_reg;
  ubs_baud_st_t st_next;

  // ****************************************************************
  // divide by n+1
  // ****************************************************************
  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (!run)
    begin
      st_next.cnt = divider;
    end
    else if (st_reg.cnt == 8'h00)
    begin
      // new value takes effect at the reload only
      st_next.cnt  = divider;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '{cnt: `UBS_RST_BAUD, tick: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign tick16 = st_reg.tick;

endmodule

// ---- hdl/ubs_uart.sv ----
/*
  Serial channel with AHB-Lite register slave: mode, control, receive
  buffer with error flags, transmit buffer, baud divider, and the frame
  shifters on the serial pins. Assumes a single AHB-Lite master, word
  accesses only, and an asynchronous serial_in_pin.
*/
// What this block does
// [R1] receive complete reads at channel_control_one b3, 1 when a byte waits.
// [R2] the received byte reads from receive_buffer bits 7..0, read only.
// [R3] overrun error flag reads at receive_buffer b12.
// [R4] framing error flag reads at receive_buffer b13.
// [R5] parity error flag reads at receive_buffer b14.
// [R6] error sum flag reads at receive_buffer b15.
// [R7] transmit buffer empty reads at channel_control_one b1, read only.
// [R8] software writes the byte to send into transmit_buffer bits 7..0.
// [R9] software polls receive complete before reading receive_buffer.
// [R10] software polls transmit buffer empty before writing the next byte.
// [R11] serial mode field 1 0 1 runs the channel as an 8-bit UART.
// [R12] bit rate is hclk divided by the divider plus one, then by 16.
// [R13] the transmit enable bit allows or stops transmission.
// [R14] error sum is the OR of overrun, framing and parity errors.
// [R15] transmit buffer empty is 0 while data waits, 1 once it is moved.
`timescale 1ns/100ps
`include "ubs_defines.svh"

module ubs_uart
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin
);
  import ubs_pkg::*;

  ubs_st_t    st_reg;
  ubs_st_t    st_next;
  logic       tick16;
  logic       active;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic parity_of(input logic [7:0] d,
                                     input logic       even);
    parity_of = even ? (^d) : ~(^d);
  endfunction

  // [R11] only mode 1 0 1 runs
  assign active = (st_reg.smd == `UBS_SMD_UART8);

  // [R12] count source divided by n+1
  ubs_baud_gen ubs_baud_gen_i
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (active),
    .divider (st_reg.baud),
    .tick16  (tick16)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic       rd_clear;
    logic       bit_in;
    logic [3:0] rx_total;
    logic [7:0] rx_byte;
    rd_clear      = 1'b0;
    bit_in        = 1'b0;
    rx_total      = `UBS_RX_BITS_BASE + {3'h0, st_reg.par_en};
    rx_byte       = 8'h00;
    st_next       = st_reg;
    st_next.hresp = 1'b0;

    // two-stage sync of the receive pin
    st_next.rx_sync1 = serial_in_pin;
    st_next.rx_sync2 = st_reg.rx_sync1;

    // bus address phase; reads get one wait state so that hrdata
    // comes from a flop and sees the effect of a preceding write
    st_next.pend_wr = 1'b0;
    st_next.pend_rd = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      st_next.addr    = haddr[7:0];
      st_next.pend_wr = hwrite;
      st_next.pend_rd = !hwrite;
      st_next.hready  = hwrite;
    end

    // read data phase
    if (st_reg.pend_rd)
    begin
      st_next.hready = 1'b1;
      st_next.hrdata = 32'h0000_0000;
      if (st_reg.addr == `UBS_OFS_MODE)
      begin
        st_next.hrdata[`UBS_MODE_SMD_HI:`UBS_MODE_SMD_LO] = st_reg.smd;
        st_next.hrdata[`UBS_MODE_STOP2]    = st_reg.stop2;
        st_next.hrdata[`UBS_MODE_PAR_EVEN] = st_reg.par_even;
        st_next.hrdata[`UBS_MODE_PAR_EN]   = st_reg.par_en;
      end
      else if (st_reg.addr == `UBS_OFS_CTRL1)
      begin
        st_next.hrdata[`UBS_C1_TX_EN] = st_reg.tx_en;
        // [R7] empty flag, inverse of buffer full
        st_next.hrdata[`UBS_C1_TX_EMPTY] = !st_reg.tx_full;
        st_next.hrdata[`UBS_C1_RE] = st_reg.re;
        // [R1] receive complete
        st_next.hrdata[`UBS_C1_RX_DONE] = st_reg.rx_done;
      end
      else if (st_reg.addr == `UBS_OFS_RXBUF)
      begin
        // [R2] received byte
        st_next.hrdata[7:0]         = st_reg.rb_data;
        // [R3] overrun flag
        st_next.hrdata[`UBS_RB_OVERRUN] = st_reg.overrun;
        // [R4] framing flag
        st_next.hrdata[`UBS_RB_FRAMING] = st_reg.framing;
        // [R5] parity flag
        st_next.hrdata[`UBS_RB_PARITY] = st_reg.par_err;
        // [R6] [R14] error sum as OR
        st_next.hrdata[`UBS_RB_SUM] = st_reg.overrun | st_reg.framing
                                      | st_reg.par_err;
        // [R9] reading the buffer consumes the byte
        rd_clear = 1'b1;
      end
      else if (st_reg.addr == `UBS_OFS_BAUD)
      begin
        st_next.hrdata[7:0] = st_reg.baud;
      end
    end

    // write data phase; unmapped and read-only bits are ignored
    if (st_reg.pend_wr)
    begin
      if (st_reg.addr == `UBS_OFS_MODE)
      begin
        st_next.smd      = hwdata[`UBS_MODE_SMD_HI:`UBS_MODE_SMD_LO];
        st_next.stop2    = hwdata[`UBS_MODE_STOP2];
        st_next.par_even = hwdata[`UBS_MODE_PAR_EVEN];
        st_next.par_en   = hwdata[`UBS_MODE_PAR_EN];
      end
      else if (st_reg.addr == `UBS_OFS_CTRL1)
      begin
        st_next.tx_en = hwdata[`UBS_C1_TX_EN];
        st_next.re = hwdata[`UBS_C1_RE];
      end
      else if (st_reg.addr == `UBS_OFS_BAUD)
      begin
        st_next.baud = hwdata[7:0];
      end
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    case (st_reg.tx_state)
      UBS_TX_IDLE:
      begin
        st_next.txd = 1'b1;
        // [R13] a frame starts only while transmit is enabled
        if (active && st_reg.tx_en && st_reg.tx_full)
        begin
          st_next.tx_state = UBS_TX_RUN;
          st_next.txd      = 1'b0;
          st_next.tx_sub   = 4'h0;
          st_next.tx_left  = `UBS_TX_BITS_BASE
                             + {3'h0, st_reg.par_en}
                             + {3'h0, st_reg.stop2};
          st_next.tx_shift = {2'b11,
                              st_reg.par_en
                                ? parity_of(st_reg.tx_buf,
                                            st_reg.par_even)
                                : 1'b1,
                              st_reg.tx_buf};
          // [R15] buffer moved to the shifter
          st_next.tx_full  = 1'b0;
        end
      end
      UBS_TX_RUN:
      begin
        if (!active)
        begin
          st_next.tx_state = UBS_TX_IDLE;
          st_next.txd      = 1'b1;
        end
        else if (tick16)
        begin
          st_next.tx_sub = st_reg.tx_sub + 4'h1;
          // [R12] one bit per sixteen ticks
          if (st_reg.tx_sub == `UBS_OVERSAMPLE_MAX)
          begin
            if (st_reg.tx_left == 4'h0)
            begin
              st_next.tx_state = UBS_TX_IDLE;
            end
            else
            begin
              st_next.txd      = st_reg.tx_shift[0];
              st_next.tx_shift = {1'b1, st_reg.tx_shift[10:1]};
              st_next.tx_left  = st_reg.tx_left - 4'h1;
            end
          end
        end
      end
      default:
      begin
        st_next.tx_state = UBS_TX_IDLE;
        st_next.txd      = 1'b1;
      end
    endcase

    // [R8] low byte loads the buffer; a write in the load cycle wins
    if (st_reg.pend_wr && st_reg.addr == `UBS_OFS_TXBUF)
    begin
      st_next.tx_buf  = hwdata[7:0];
      // [R15] data waiting, empty flag drops
      st_next.tx_full = 1'b1;
    end

    // ****************************************************************
    // receiver
    // ****************************************************************
    // [R1] read clears, a completing frame below sets again
    if (rd_clear)
    begin
      st_next.rx_done = 1'b0;
    end
    case (st_reg.rx_state)
      UBS_RX_IDLE:
      begin
        if (active && st_reg.re && !st_reg.rx_sync2)
        begin
          st_next.rx_state = UBS_RX_RUN;
          st_next.rx_sub   = 4'h0;
          st_next.rx_left  = rx_total;
        end
      end
      UBS_RX_RUN:
      begin
        if (!active || !st_reg.re)
        begin
          st_next.rx_state = UBS_RX_IDLE;
        end
        else if (tick16)
        begin
          st_next.rx_sub = st_reg.rx_sub + 4'h1;
          if (st_reg.rx_sub == `UBS_MID_SAMPLE)
          begin
            bit_in = st_reg.rx_sync2;
            st_next.rx_shift = {bit_in, st_reg.rx_shift[9:1]};
            st_next.rx_left  = st_reg.rx_left - 4'h1;
            // glitch rejected: start bit high at mid-bit
            if (st_reg.rx_left == rx_total && bit_in)
            begin
              st_next.rx_state = UBS_RX_IDLE;
            end
            else if (st_reg.rx_left == 4'h1)
            begin
              st_next.rx_state = UBS_RX_IDLE;
              rx_byte = st_reg.par_en ? st_reg.rx_shift[8:1]
                                      : st_reg.rx_shift[9:2];
              // [R2] new byte; an unread one is overwritten
              st_next.rb_data = rx_byte;
              // [R3] unread byte still held and not read now
              st_next.overrun = st_reg.rx_done && !rd_clear;
              // [R4] stop bit low
              st_next.framing = !bit_in;
              // [R5] parity mismatch
              st_next.par_err = st_reg.par_en
                                && (st_reg.rx_shift[9]
                                    != parity_of(rx_byte,
                                                 st_reg.par_even));
              // [R1] set wins over a read in the same cycle
              st_next.rx_done = 1'b1;
            end
          end
        end
      end
      default:
      begin
        st_next.rx_state = UBS_RX_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg          <= '0;
      st_reg.smd      <= `UBS_RST_SMD;
      st_reg.baud     <= `UBS_RST_BAUD;
      st_reg.hready   <= 1'b1;
      st_reg.txd      <= 1'b1;
      st_reg.rx_sync1 <= 1'b1;
      st_reg.rx_sync2 <= 1'b1;
      st_reg.tx_state <= UBS_TX_IDLE;
      st_reg.rx_state <= UBS_RX_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign hreadyout      = st_reg.hready;
  assign hresp          = st_reg.hresp;
  assign hrdata         = st_reg.hrdata;
  assign serial_out_pin = st_reg.txd;

endmodule

// ---- verification/ubs_uart_assertions.sv ----
/*
  Port checker for ubs_uart: bus timing, read data layout, start bit.
  Assumes one AHB-Lite master and hready tied to hreadyout.
*/
`timescale 1ns/100ps
`include "ubs_defines.svh"

module ubs_uart_assertions
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin
);
  logic rd_q;
  logic rd_q2;
  wire  take = hsel && hready && htrans[1];

  // rd_q2 marks the cycle in which read data is presented
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_q  <= 1'b0;
      rd_q2 <= 1'b0;
    end
    else
    begin
      rd_q  <= take && !hwrite;
      rd_q2 <= rd_q;
    end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd(logic [7:0] a);
    take && !hwrite && haddr[7:0] == a;
  endsequence
  sequence s_wait_ready;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_read_wait;
    take && !hwrite |=> s_wait_ready;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read did not wait exactly one cycle");
  property p_write_nowait;
    take && hwrite |=> hreadyout && !hresp;
  endproperty
  a_write_nowait: assert property (p_write_nowait)
    else $error("write stalled or failed");
  property p_ctrl_width;
    s_rd(`UBS_OFS_CTRL1) |=> ##1 hrdata[31:4] == 28'h0;
  endproperty
  a_ctrl_width: assert property (p_ctrl_width)
    else $error("control read has bits above b3");
  property p_sum_or;
    s_rd(`UBS_OFS_RXBUF) |=> ##1 hrdata[15] == |hrdata[14:12];
  endproperty
  a_sum_or: assert property (p_sum_or)
    else $error("error sum differs from error flags");
  property p_rb_pad;
    s_rd(`UBS_OFS_RXBUF) |=> ##1 hrdata[31:16] == 16'h0
      && hrdata[11:8] == 4'h0;
  endproperty
  a_rb_pad: assert property (p_rb_pad)
    else $error("receive buffer unused bits set");
  property p_tb_wo;
    s_rd(`UBS_OFS_TXBUF) |=> ##1 hrdata == 32'h0;
  endproperty
  a_tb_wo: assert property (p_tb_wo)
    else $error("transmit buffer read back data");
  property p_hold;
    !rd_q2 |-> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved outside a read");
  // shortest bit is sixteen clocks, divider zero
  property p_start_len;
    $fell(serial_out_pin) |-> (!serial_out_pin)[*8] ##1
      (!serial_out_pin)[*8];
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("start bit shorter than sixteen clocks");
endmodule

bind ubs_uart ubs_uart_assertions ubs_uart_assertions_i
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin)
);

// ---- verification/ubs_remote.sv ----
/*
  Remote serial partner: sends frames with chosen faults and decodes
  frames from the channel. Assumes even parity, one stop bit and a bit
  time of BIT hclk cycles.
*/
`timescale 1ns/100ps

module ubs_remote
#(
  parameter int BIT = 32
)
(
  input  wire logic hclk,
  input  wire logic line_in,
  output logic      line_out
);
  // {stop ok, parity ok, data}
  logic [9:0] got[$];

  initial line_out = 1'b1;

  task automatic send(input logic [7:0] d, input logic bad_par,
                      input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge hclk) line_out <= f[i];
      // short low stop avoids a false start after it
      repeat ((i == 10 && bad_stop) ? BIT / 2 + 4 : BIT - 1)
        @(posedge hclk);
    end
    @(posedge hclk) line_out <= 1'b1;
    repeat (2 * BIT) @(posedge hclk);
  endtask

  always
  begin
    logic [9:0] r;
    @(negedge line_in);
    repeat (BIT / 2) @(posedge hclk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (BIT) @(posedge hclk);
      r[i] = line_in;
    end
    got.push_back({r[9], ~^r[8:0], r[7:0]});
  end
endmodule

// ---- verification/tb_ubs_uart.sv ----
/*
  Self-checking bench of ubs_uart over AHB-Lite with a remote serial
  partner. Assumes the defines header and divider 1 (32 clocks/bit).
*/
`timescale 1ns/100ps
`include "ubs_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected at %0t: %h vs %h", $time, g, e); \
  end end

module tb_ubs_uart;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        serial_in_pin;
  logic        serial_out_pin;
  int          bad_count;
  int          tests_run;
  int          cycles;

  ubs_uart ubs_uart_i
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin)
  );
  ubs_remote #(.BIT(32)) ubs_remote_i
  (
    .hclk(hclk), .line_in(serial_out_pin), .line_out(serial_in_pin)
  );

  always #10 hclk = ~hclk;

  task wrap_up;
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard, about six times the expected run
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d,
           output logic [31:0] r);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    `CHK(r, e)
  endtask

  task poll(input int b, input logic v);
    logic [31:0] r;
    do bus(`UBS_OFS_CTRL1, 1'b0, 32'h0, r); while (r[b] !== v);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    rd_chk(`UBS_OFS_CTRL1, 32'h2);
    rd_chk(`UBS_OFS_RXBUF, 32'h0);
    rd_chk(`UBS_OFS_TXBUF, 32'h0);
    rd_chk(8'h14, 32'h0);
    wr(`UBS_OFS_MODE, 32'h65);
    wr(`UBS_OFS_BAUD, 32'h1);
    wr(`UBS_OFS_CTRL1, 32'h4);
    rd_chk(`UBS_OFS_BAUD, 32'h1);
  endtask

  task t_tx;
    poll(`UBS_C1_TX_EMPTY, 1'b1);
    wr(`UBS_OFS_TXBUF, 32'h3ca5);
    repeat (64) @(posedge hclk);
    rd_chk(`UBS_OFS_CTRL1, 32'h4);
    `CHK(ubs_remote_i.got.size(), 0)
    wr(`UBS_OFS_CTRL1, 32'h5);
    rd_chk(`UBS_OFS_CTRL1, 32'h7);
    wr(`UBS_OFS_TXBUF, 32'h5a);
    rd_chk(`UBS_OFS_CTRL1, 32'h5);
    poll(`UBS_C1_TX_EMPTY, 1'b1);
    wr(`UBS_OFS_TXBUF, 32'h0f);
    wait (ubs_remote_i.got.size() == 3);
    `CHK(ubs_remote_i.got[0], 10'h3a5)
    `CHK(ubs_remote_i.got[1], 10'h35a)
    `CHK(ubs_remote_i.got[2], 10'h30f)
  endtask

  task t_rx(input logic [7:0] d, input logic bp, input logic bs,
            input logic [31:0] e);
    ubs_remote_i.send(d, bp, bs);
    poll(`UBS_C1_RX_DONE, 1'b1);
    rd_chk(`UBS_OFS_RXBUF, e);
    rd_chk(`UBS_OFS_CTRL1, 32'h7);
  endtask

  // odd parity, two stops; the partner's odd frame is clean here
  task t_odd;
    wr(`UBS_OFS_MODE, 32'h55);
    t_rx(8'h3c, 1'b1, 1'b0, 32'h3c);
    poll(`UBS_C1_TX_EMPTY, 1'b1);
    wr(`UBS_OFS_TXBUF, 32'h96);
    wait (ubs_remote_i.got.size() == 4);
    `CHK(ubs_remote_i.got[3], 10'h296)
    wr(`UBS_OFS_MODE, 32'h65);
  endtask

  initial
  begin
    hclk    = 1'b0;
    // nba so the async reset sees a clean fall at time zero
    hresetn <= 1'b0;
    hsel    = 1'b1;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_tx();
    t_odd();
    t_rx(8'h3c, 1'b0, 1'b0, 32'h3c);
    t_rx(8'h81, 1'b1, 1'b0, 32'hc081);
    t_rx(8'h7e, 1'b0, 1'b1, 32'ha07e);
    ubs_remote_i.send(8'h11, 1'b0, 1'b0);
    t_rx(8'h22, 1'b0, 1'b0, 32'h9022);
    wr(`UBS_OFS_MODE, 32'h0);
    ubs_remote_i.send(8'h55, 1'b0, 1'b0);
    rd_chk(`UBS_OFS_CTRL1, 32'h7);
    wrap_up();
  end
endmodule
